/* File: hw/ctmc_pkg.sv */
/*
  Package for the transceiver mode control block: mode encodings,
  chip operating modes, timing constants and the enabling delay.
  Assumes a single 20 MHz device clock and an active-low power-up reset.
*/
// Function
// - After power-up the transceiver is off, with no bus drive and no wake detection.
// - The off mode can be selected whatever the chip operating mode is.
// - In off mode bus wake activity is ignored: no flag, no mode or receive change.
// - Normal mode is entered only by a command and only while the chip is in normal mode.
// - In normal mode a low transmit input drives the bus dominant, high leaves it recessive.
// - A low transmit input during the delay is dropped until the transmit input goes high after the delay.
// - In normal and receive-only modes the receiver level is shown on the receive output, low dominant, high recessive.
// - A receive-only mode keeps reporting bus reception for diagnostics.
// - In wake-capable mode a bus wake pattern is detected and reported as a wake event.
// - Wake-capable mode can be selected while the chip is in normal mode.
// - The data path passes bits up to 2 megabaud without altering their content.
// - Receive-only disables the driver, keeps reception, and is allowed in normal and stop.
// - After a bus wake the receive output is held low until another mode is selected.
// - Mode still reads wake-capable after a wake; rearm needs a change away and back.

package ctmc_pkg;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] CTMC_MODE_OFF  = 2'h0;
  localparam logic [1:0] CTMC_MODE_WAKE = 2'h1;
  localparam logic [1:0] CTMC_MODE_RXO  = 2'h2;
  localparam logic [1:0] CTMC_MODE_NORM = 2'h3;

  localparam logic [1:0] CTMC_CHIP_NORMAL  = 2'h0;
  localparam logic [1:0] CTMC_CHIP_STOP    = 2'h1;
  localparam logic [1:0] CTMC_CHIP_SLEEP   = 2'h2;
  localparam logic [1:0] CTMC_CHIP_RESTART = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CTMC_CLK_MHZ     = 20;
  localparam int CTMC_EN_TIME_US  = 10;   // Enabling delay, least time
  localparam int CTMC_EN_CYC      = CTMC_EN_TIME_US * CTMC_CLK_MHZ;
  localparam int CTMC_WAKE_MIN_US = 1;    // Least dominant/recessive phase
  localparam int CTMC_WAKE_MIN_CYC = CTMC_WAKE_MIN_US * CTMC_CLK_MHZ;
  localparam int CTMC_CNT_W       = 12;
  localparam logic [CTMC_CNT_W-1:0] CTMC_CNT_RST = 12'h000;
  localparam logic [1:0] CTMC_MODE_RST = CTMC_MODE_OFF;

  typedef enum logic [2:0] {
    CTMC_WK_IDLE, CTMC_WK_DOM1, CTMC_WK_REC, CTMC_WK_DOM2, CTMC_WK_DONE
  } ctmc_wake_e;

endpackage : ctmc_pkg

/* File: hw/ctmc_skid_buf.sv */
/*
  Two-entry buffer with valid/ready on both sides for one-bit samples.
  Assumes the single device clock and asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none

module ctmc_skid_buf (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // Fill side
  input  wire logic i_valid,
  output logic      o_ready,
  input  wire logic i_data,
  // Drain side
  output logic      o_valid,
  input  wire logic i_ready,
  output logic      o_data
);
  import ctmc_pkg::*;

  logic [1:0] mem_q, mem_d;
  logic       wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic       push, pop;

  // ---------------------------------------------------------------
  // Pointer and storage update
  // ---------------------------------------------------------------
  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem_q[rp_q];          // Storage is a flop array

  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = i_data;
      wp_d        = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_q <= 2'h3;                     // Recessive content
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

endmodule // ctmc_skid_buf

`default_nettype wire

/* File: hw/ctmc_mode_ctrl.sv */
/*
  Transceiver mode control and digital transmit/receive path.
  Assumes mode requests arrive as one-cycle pulses from the serial
  register logic, chip mode is a stable level, and the analog
  receiver output is synchronous to i_ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module ctmc_mode_ctrl (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // Mode request
  input  wire logic       i_mode_req,
  input  wire logic [1:0] i_mode_sel,
  input  wire logic [1:0] i_chip_mode,
  output logic [1:0]      o_mode,
  output logic            o_tx_ready,
  // Controller side
  input  wire logic       i_tx_data_in,
  output logic            o_rx_data_out,
  // Bus side
  output logic            o_bus_drive_dom,
  input  wire logic       i_bus_rx_dom,
  // Wake reporting
  output logic            o_wake_event,
  output logic            o_wake_flag,
  input  wire logic       i_wake_flag_clr,
  // Receive buffer back-pressure
  output logic            o_rx_valid,
  input  wire logic       i_rx_ready
);
  import ctmc_pkg::*;

  // ---------------------------------------------------------------
  // Mode register and enabling delay
  // ---------------------------------------------------------------
  logic [1:0]            mode_q, mode_d;
  logic [CTMC_CNT_W-1:0] en_cnt_q, en_cnt_d;
  logic                  en_done_q, en_done_d;
  logic                  tx_block_q, tx_block_d;
  logic                  armed_q, armed_d;
  logic                  woken_q, woken_d;
  logic                  req_ok;
  logic                  wake_hit;

  // Gate requests by chip mode; refused ones leave mode untouched
  always_comb begin
    case (i_mode_sel)
      CTMC_MODE_OFF:  req_ok = 1'b1;
      CTMC_MODE_NORM: req_ok = (i_chip_mode == CTMC_CHIP_NORMAL);
      CTMC_MODE_RXO:  req_ok = (i_chip_mode == CTMC_CHIP_NORMAL) ||
                               (i_chip_mode == CTMC_CHIP_STOP);
      CTMC_MODE_WAKE: req_ok = 1'b1;
      default:        req_ok = 1'b0;
    endcase
  end

  // Next mode, enabling counter, wake arming
  always_comb begin
    mode_d     = mode_q;
    en_cnt_d   = en_cnt_q;
    en_done_d  = en_done_q;
    tx_block_d = tx_block_q;
    armed_d    = armed_q;
    woken_d    = woken_q;
    if (i_mode_req && req_ok && (i_mode_sel != mode_q)) begin
      mode_d  = i_mode_sel;
      woken_d = 1'b0;                    // Leaving wake releases hold
      armed_d = (i_mode_sel == CTMC_MODE_WAKE); // Rearm only on fresh entry
      if (i_mode_sel == CTMC_MODE_NORM) begin
        en_cnt_d   = CTMC_CNT_RST;       // Delay starts at entry
        en_done_d  = 1'b0;
        tx_block_d = 1'b0;
      end
    end else begin
      if ((mode_q == CTMC_MODE_NORM) && !en_done_q) begin
        if (!i_tx_data_in) begin
          tx_block_d = 1'b1;             // Early dominant is remembered
        end
        if (en_cnt_q == CTMC_CNT_W'(CTMC_EN_CYC - 1)) begin
          en_done_d = 1'b1;
        end else begin
          en_cnt_d = en_cnt_q + 1'b1;
        end
      end else if (tx_block_q && i_tx_data_in) begin
        tx_block_d = 1'b0;               // Next dominant after release goes out
      end
      if (wake_hit) begin
        woken_d = 1'b1;                  // Mode field stays wake-capable
        armed_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q     <= CTMC_MODE_RST;       // Off after power-up
      en_cnt_q   <= CTMC_CNT_RST;
      en_done_q  <= 1'b0;
      tx_block_q <= 1'b0;
      armed_q    <= 1'b0;
      woken_q    <= 1'b0;
    end else begin
      mode_q     <= mode_d;
      en_cnt_q   <= en_cnt_d;
      en_done_q  <= en_done_d;
      tx_block_q <= tx_block_d;
      armed_q    <= armed_d;
      woken_q    <= woken_d;
    end
  end

  // ---------------------------------------------------------------
  // Wake pattern detector: dominant, recessive, dominant phases
  // ---------------------------------------------------------------
  ctmc_wake_e            wk_q, wk_d;
  logic [CTMC_CNT_W-1:0] wk_cnt_q, wk_cnt_d;
  logic                  wk_long;

  assign wk_long = (wk_cnt_q >= CTMC_CNT_W'(CTMC_WAKE_MIN_CYC - 1));

  // Only runs while armed in wake mode; off mode never sees a wake
  always_comb begin
    wk_d     = wk_q;
    wk_cnt_d = wk_cnt_q;
    wake_hit = 1'b0;
    if (!((mode_q == CTMC_MODE_WAKE) && armed_q)) begin
      wk_d     = CTMC_WK_IDLE;
      wk_cnt_d = CTMC_CNT_RST;
    end else begin
      case (wk_q)
        CTMC_WK_IDLE: begin
          wk_cnt_d = CTMC_CNT_RST;
          if (i_bus_rx_dom) wk_d = CTMC_WK_DOM1;
        end
        CTMC_WK_DOM1, CTMC_WK_DOM2: begin
          if (!wk_long) wk_cnt_d = wk_cnt_q + 1'b1;
          if (!i_bus_rx_dom) begin
            wk_cnt_d = CTMC_CNT_RST;
            if (!wk_long)                wk_d = CTMC_WK_IDLE; // Glitch filtered
            else if (wk_q == CTMC_WK_DOM1) wk_d = CTMC_WK_REC;
            else                         wk_d = CTMC_WK_DONE;
          end
        end
        CTMC_WK_REC: begin
          if (!wk_long) wk_cnt_d = wk_cnt_q + 1'b1;
          if (i_bus_rx_dom) begin
            wk_cnt_d = CTMC_CNT_RST;
            wk_d     = wk_long ? CTMC_WK_DOM2 : CTMC_WK_DOM1;
          end
        end
        CTMC_WK_DONE: begin
          wake_hit = 1'b1;
          wk_d     = CTMC_WK_IDLE;
        end
        default: wk_d = CTMC_WK_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wk_q     <= CTMC_WK_IDLE;
      wk_cnt_q <= CTMC_CNT_RST;
    end else begin
      wk_q     <= wk_d;
      wk_cnt_q <= wk_cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // Transmit path and wake flag outputs
  // ---------------------------------------------------------------
  logic drive_q, drive_d;
  logic flag_q, flag_d;
  logic evt_q, evt_d;

  // Registered so the driver never glitches; one cycle latency is far
  // below a 2 Mbaud bit time of 500 ns (10 clocks)
  always_comb begin
    drive_d = (mode_q == CTMC_MODE_NORM) && en_done_q && !tx_block_q &&
              !i_tx_data_in;
    evt_d   = wake_hit;
    flag_d  = flag_q;
    if (i_wake_flag_clr) flag_d = 1'b0;
    if (wake_hit)        flag_d = 1'b1;   // Set wins over clear
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drive_q <= 1'b0;
      flag_q  <= 1'b0;
      evt_q   <= 1'b0;
    end else begin
      drive_q <= drive_d;
      flag_q  <= flag_d;
      evt_q   <= evt_d;
    end
  end

  // ---------------------------------------------------------------
  // Receive path through the two-entry buffer
  // ---------------------------------------------------------------
  logic rx_in, rx_buf, rx_buf_ready;

  // Active modes report the bus; wake hold forces low; else recessive
  assign rx_in = woken_q ? 1'b0 :
                 ((mode_q == CTMC_MODE_NORM) || (mode_q == CTMC_MODE_RXO)) ?
                 !i_bus_rx_dom : 1'b1;

  ctmc_skid_buf u_rx_buf (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_valid   (1'b1),
    .o_ready   (rx_buf_ready),
    .i_data    (rx_in),
    .o_valid   (o_rx_valid),
    .i_ready   (i_rx_ready),
    .o_data    (rx_buf)
  );

  // Output holds last delivered level; a stalled receiver sees no change
  logic rx_out_q, rx_out_d;
  always_comb begin
    rx_out_d = rx_out_q;
    if (o_rx_valid && i_rx_ready) rx_out_d = rx_buf;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_out_q <= 1'b1;
    end else begin
      rx_out_q <= rx_out_d;
    end
  end

  assign o_rx_data_out   = rx_out_q;
  assign o_bus_drive_dom = drive_q;
  assign o_mode          = mode_q;
  assign o_tx_ready      = en_done_q && !tx_block_q && rx_buf_ready;
  assign o_wake_flag     = flag_q;
  assign o_wake_event    = evt_q;

endmodule // ctmc_mode_ctrl

`default_nettype wire

/* File: testbench/ctmc_mode_ctrl_sva.sv */
/* Port checker for the transceiver mode control block.
   Assumes one clock domain and a bind from the bench top. */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------
// Mode checker
// ---------------------------------------------
module ctmc_mode_ctrl_sva
  import ctmc_pkg::*;
(
  // Clock and reset
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  // Watched ports
  input wire logic       i_mode_req,
  input wire logic [1:0] i_mode_sel,
  input wire logic [1:0] i_chip_mode,
  input wire logic [1:0] o_mode,
  input wire logic       i_tx_data_in,
  input wire logic       o_rx_data_out,
  input wire logic       o_bus_drive_dom,
  input wire logic       o_wake_event,
  input wire logic       o_wake_flag
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  // Cycles in normal mode; saturates so a long stay cannot wrap
  always_comb begin
    cnt_d = cnt_q;
    if (o_mode != CTMC_MODE_NORM) cnt_d = 12'h000;
    else if (cnt_q != 12'hFFF) cnt_d = cnt_q + 12'h001;
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) cnt_q <= 12'h000;
    else cnt_q <= cnt_d;
  end
  // Receive line must follow a wake within a few cycles
  sequence rx_goes_low;
    ##[0:4] !o_rx_data_out;
  endsequence
  norm_gate_a: assert property (o_mode == CTMC_MODE_NORM && $past(o_mode) != CTMC_MODE_NORM
    |-> $past(i_mode_req) && $past(i_chip_mode) == CTMC_CHIP_NORMAL)
    else $error("normal mode entered without a legal request");
  norm_refuse_a: assert property (i_mode_req && i_mode_sel == CTMC_MODE_NORM
    && i_chip_mode != CTMC_CHIP_NORMAL |=> $stable(o_mode)) else $error("refused request moved mode");
  off_any_a: assert property (i_mode_req && i_mode_sel == CTMC_MODE_OFF
    |=> o_mode == CTMC_MODE_OFF) else $error("off request not honoured");
  drive_tx_a: assert property (o_bus_drive_dom |-> !$past(i_tx_data_in))
    else $error("dominant drive without low transmit input");
  rxo_quiet_a: assert property (o_mode == CTMC_MODE_RXO |=> !o_bus_drive_dom)
    else $error("driver active in receive-only mode");
  drive_delay_a: assert property (o_bus_drive_dom |-> cnt_q >= CTMC_EN_CYC - 1)
    else $error("drive before enabling delay");
  off_nowake_a: assert property (o_mode == CTMC_MODE_OFF && $past(o_mode) == CTMC_MODE_OFF
    |-> !o_wake_event) else $error("wake reported in off mode");
  wake_pulse_a: assert property (o_wake_event |=> !o_wake_event && o_wake_flag)
    else $error("wake event not a single pulse with flag");
  wake_rx_a: assert property (o_wake_event |-> rx_goes_low)
    else $error("receive output not low after wake");
  wake_keep_a: assert property (o_wake_event |-> o_mode == CTMC_MODE_WAKE)
    else $error("mode changed by wake");
endmodule // ctmc_mode_ctrl_sva
`default_nettype wire

/* File: testbench/ctmc_bus_model.sv */
/* Bus partner: wired dominance of this driver and other nodes.
   Assumes other nodes' dominance comes from the bench as a level. */
`timescale 1ns/10ps
`default_nettype none
module ctmc_bus_model (
  // Drivers
  input  wire logic i_drive_dom,
  input  wire logic i_node_dom,
  // Receiver view
  output logic      o_rx_dom
);
  // Dominant wins; recessive only when nobody drives
  assign o_rx_dom = i_drive_dom | i_node_dom;
endmodule // ctmc_bus_model
`default_nettype wire

/* File: testbench/tb_ctmc_mode_ctrl.sv */
/* Bench for the mode control block: scenario tasks and self-checks.
   Assumes package, design, bus model and checker compiled first. */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------
// Bench top
// ---------------------------------------------
module tb_ctmc_mode_ctrl;
  import ctmc_pkg::*;
  logic       ref_clk, rst_n, req, tx, rx_out, drive, rx_dom, wev, wflag;
  logic       wclr, rx_valid, rx_ready, node_dom, tx_ready;
  logic [1:0] sel, chip, mode;
  int         mismatches, n_checks;

  // Clock of 50 ns
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  ctmc_mode_ctrl i_ctmc_mode_ctrl (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_mode_req(req),
    .i_mode_sel(sel), .i_chip_mode(chip), .o_mode(mode), .o_tx_ready(tx_ready),
    .i_tx_data_in(tx), .o_rx_data_out(rx_out), .o_bus_drive_dom(drive),
    .i_bus_rx_dom(rx_dom), .o_wake_event(wev), .o_wake_flag(wflag),
    .i_wake_flag_clr(wclr), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready));
  ctmc_bus_model i_ctmc_bus_model (.i_drive_dom(drive), .i_node_dom(node_dom),
    .o_rx_dom(rx_dom));

  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %b want %b", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Request pulse; a falling edge passes first so pulses never merge
  task automatic set_mode(input logic [1:0] m, input logic [1:0] c);
    @(negedge ref_clk);
    req = 1'b1;
    sel = m;
    chip = c;
    @(negedge ref_clk);
    req = 1'b0;
  endtask
  // Dominant, recessive, dominant, each 25 cycles, past the 20 minimum
  task automatic wake_pat();
    node_dom = 1'b1;
    cyc(25);
    node_dom = 1'b0;
    cyc(25);
    node_dom = 1'b1;
    cyc(25);
    node_dom = 1'b0;
    cyc(6);
  endtask
  task automatic t_off();
    chk(mode, CTMC_MODE_OFF);
    chk(drive, 1'b0);
    chk(tx_ready, 1'b0);
    wake_pat();
    chk(wflag, 1'b0);
    chk(rx_out, 1'b1);
    $display("test off done");
  endtask
  task automatic t_norm();
    set_mode(CTMC_MODE_NORM, CTMC_CHIP_STOP);
    chk(mode, CTMC_MODE_OFF);
    set_mode(CTMC_MODE_NORM, CTMC_CHIP_NORMAL);
    chk(mode, CTMC_MODE_NORM);
    tx = 1'b0;
    cyc(20);
    chk(drive, 1'b0);
    chk(tx_ready, 1'b0);
    // Controller backs off until the delay is over
    tx = 1'b1;
    cyc(200);
    chk(tx_ready, 1'b1);
    chk(drive, 1'b0);
    tx = 1'b0;
    cyc(2);
    chk(drive, 1'b1);
    cyc(4);
    chk(rx_out, 1'b0);
    tx = 1'b1;
    cyc(6);
    chk({drive, rx_out}, 2'h1);
    $display("test normal done");
  endtask
  task automatic t_rxo();
    set_mode(CTMC_MODE_RXO, CTMC_CHIP_STOP);
    chk(mode, CTMC_MODE_RXO);
    tx = 1'b0;
    rx_ready = 1'b0;
    node_dom = 1'b1;
    cyc(6);
    chk(drive, 1'b0);
    chk({rx_valid, rx_out}, 2'h3);
    rx_ready = 1'b1;
    tx = 1'b1;
    cyc(6);
    chk(rx_out, 1'b0);
    node_dom = 1'b0;
    cyc(6);
    chk(rx_out, 1'b1);
    $display("test receive-only done");
  endtask
  task automatic t_wake();
    set_mode(CTMC_MODE_WAKE, CTMC_CHIP_NORMAL);
    chk(mode, CTMC_MODE_WAKE);
    wake_pat();
    chk({wflag, rx_out}, 2'h2);
    chk(mode, CTMC_MODE_WAKE);
    wclr = 1'b1;
    cyc(1);
    wclr = 1'b0;
    cyc(1);
    chk(wflag, 1'b0);
    wake_pat();
    chk(wflag, 1'b0);
    set_mode(CTMC_MODE_OFF, CTMC_CHIP_SLEEP);
    chk(mode, CTMC_MODE_OFF);
    cyc(6);
    chk(rx_out, 1'b1);
    set_mode(CTMC_MODE_WAKE, CTMC_CHIP_SLEEP);
    wake_pat();
    chk(wflag, 1'b1);
    $display("test wake done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence; reset held for five cycles
  initial begin
    // Reset low; controller recessive, receiver ready, bus idle
    rst_n    = 1'b0;
    req      = 1'b0;
    tx       = 1'b1;
    wclr     = 1'b0;
    rx_ready = 1'b1;
    node_dom = 1'b0;
    sel      = CTMC_MODE_OFF;
    chip     = CTMC_CHIP_NORMAL;
    mismatches = 0;
    n_checks = 0;
    cyc(5);
    rst_n = 1'b1;
    cyc(2);
    t_off();
    t_norm();
    t_rxo();
    t_wake();
    print_verdict();
  end
  // Watchdog well past the roughly 600 cycles the tests take
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    print_verdict();
  end
endmodule // tb_ctmc_mode_ctrl
bind ctmc_mode_ctrl ctmc_mode_ctrl_sva i_ctmc_mode_ctrl_sva (.i_ref_clk, .i_rst_n,
  .i_mode_req, .i_mode_sel, .i_chip_mode, .o_mode, .i_tx_data_in, .o_rx_data_out,
  .o_bus_drive_dom, .o_wake_event, .o_wake_flag);
`default_nettype wire
